/* File: core/pio_dma_ctl.v */
`timescale 1ns/100ps
`include "pio_dma_ctl_defs.vh"
// Overview of operation
// - wide bus: no selection, ignore parity
// - program phase bits for phase match
// - load byte, then set request assert
// - poll request status until active
// - check phase match, then assert ack
// - wait request false, then clear ack
// - load count and pointer before dma
// - set transfer busy bit to arm
// - then request processor idle
// - clear dma mode after interrupt, set before
module pio_dma_ctl (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  // software port
  input  wire [2:0]  addr,
  input  wire [7:0]  wdata,
  input  wire        wr,
  input  wire        rd,
  output reg  [7:0]  rdata,
  // device register bus
  output reg  [15:0] dev_addr,
  output reg  [7:0]  dev_wdata,
  output reg         dev_wr,
  output reg         dev_rd,
  input  wire [7:0]  dev_rdata,
  input  wire        dev_irq
);

////////////////////////////////////////////////////////////////////////////////
localparam S_IDLE    = 5'h00;
localparam S_RWAIT   = 5'h01;
localparam S_P_CMD   = 5'h02;
localparam S_P_DRIVE = 5'h03;
localparam S_P_DATA  = 5'h04;
localparam S_P_REQ   = 5'h05;
localparam S_P_RD1   = 5'h06;
localparam S_P_CK1   = 5'h07;
localparam S_P_RDPH  = 5'h08;
localparam S_P_CKPH  = 5'h09;
localparam S_P_ACK   = 5'h0A;
localparam S_P_RD2   = 5'h0B;
localparam S_P_CK2   = 5'h0C;
localparam S_P_CLR   = 5'h0D;
localparam S_D_CNT   = 5'h0E;
localparam S_D_PLO   = 5'h0F;
localparam S_D_PHI   = 5'h10;
localparam S_D_MODE  = 5'h11;
localparam S_D_ARM   = 5'h12;
localparam S_D_IDLE  = 5'h13;
localparam S_D_POLL  = 5'h14;
localparam S_D_CK    = 5'h15;
localparam S_D_OFF   = 5'h16;
localparam S_D_RDCNT = 5'h17;
localparam S_D_CKCNT = 5'h18;
localparam S_H_RD    = 5'h19;
localparam S_H_CK    = 5'h1A;

reg [4:0] state;
reg [4:0] ret_state;
reg [7:0] out_byte;
reg [7:0] in_byte;
reg [7:0] count;
reg [7:0] ptr_low;
reg [7:0] ptr_high;
reg [2:0] phase;
reg [7:0] high_id;
reg [7:0] left_count;
reg [4:0] status;

wire idle    = (state == S_IDLE);
wire ctrl_wr = wr && (addr == `R_CTRL) && idle;
wire go_pio  = ctrl_wr && wdata[0];
wire go_dma  = ctrl_wr && !wdata[0] && wdata[1];
wire go_hid  = ctrl_wr && !wdata[0] && !wdata[1] && wdata[2];

// target command byte: phase bits low, request assert optional
function [7:0] cmd_byte;
  input [2:0] ph;
  input       req;
  begin
    cmd_byte = {4'h0, req, ph};
  end
endfunction

////////////////////////////////////////////////////////////////////////////////
// software-loaded parameters
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    out_byte <= `RST_BYTE;
    count    <= `RST_BYTE;
    ptr_low  <= `RST_BYTE;
    ptr_high <= `RST_BYTE;
    phase    <= 3'h0;
  end else if (wr && idle) begin
    case (addr)
      `R_DATA:  out_byte <= wdata;
      `R_COUNT: count    <= wdata;
      `R_PLOW:  ptr_low  <= wdata;
      `R_PHIGH: ptr_high <= wdata;
      `R_PHASE: phase    <= wdata[2:0];
      default: ;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// sequencer driving the device registers
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    state      <= S_IDLE;
    ret_state  <= S_IDLE;
    dev_addr   <= `RST_ADDR;
    dev_wdata  <= `RST_BYTE;
    dev_wr     <= 1'b0;
    dev_rd     <= 1'b0;
    in_byte    <= `RST_BYTE;
    high_id    <= `RST_BYTE;
    left_count <= `RST_BYTE;
    status     <= 5'h00;
  end else begin
    dev_wr <= 1'b0;
    dev_rd <= 1'b0;
    // write one to clear; a set below in the same cycle wins
    if (wr && addr == `R_STATUS)
      status[4:1] <= status[4:1] & ~wdata[4:1];
    if (dev_irq && !idle)
      status[4] <= 1'b1;
    case (state)
      S_IDLE: begin
        status[0] <= 1'b0;
        if (go_pio) begin
          status[0] <= 1'b1;
          state     <= S_P_CMD;
        end else if (go_dma) begin
          status[0] <= 1'b1;
          state     <= S_D_CNT;
        end else if (go_hid) begin
          status[0] <= 1'b1;
          state     <= S_H_RD;
        end
      end
      S_RWAIT: state <= ret_state;
      S_P_CMD: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_TGT_CMD;
        dev_wdata <= cmd_byte(phase, 1'b0);
        state     <= S_P_DRIVE;
      end
      S_P_DRIVE: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_INIT_CTL;
        dev_wdata <= 8'h01 << `B_DRIVE;
        state     <= S_P_DATA;
      end
      S_P_DATA: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_OUT_DATA;
        dev_wdata <= out_byte;
        state     <= S_P_REQ;
      end
      S_P_REQ: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_TGT_CMD;
        dev_wdata <= cmd_byte(phase, 1'b1);
        state     <= S_P_RD1;
      end
      S_P_RD1: begin
        dev_rd    <= 1'b1;
        dev_addr  <= `A_BUS_LINES;
        ret_state <= S_P_CK1;
        state     <= S_RWAIT;
      end
      S_P_CK1: state <= dev_rdata[`B_REQ_STATE] ? S_P_RDPH : S_P_RD1;
      S_P_RDPH: begin
        dev_rd    <= 1'b1;
        dev_addr  <= `A_BUS_PHASE;
        ret_state <= S_P_CKPH;
        state     <= S_RWAIT;
      end
      S_P_CKPH: begin
        if (dev_rdata[`B_PHASE_OK]) begin
          state <= S_P_ACK;
        end else begin
          status[3] <= 1'b1;
          state     <= S_P_CLR;
        end
      end
      S_P_ACK: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_INIT_CTL;
        dev_wdata <= (8'h01 << `B_DRIVE) | (8'h01 << `B_ACK_ASSERT);
        state     <= S_P_RD2;
      end
      S_P_RD2: begin
        dev_rd    <= 1'b1;
        dev_addr  <= `A_BUS_LINES;
        ret_state <= S_P_CK2;
        state     <= S_RWAIT;
      end
      S_P_CK2: begin
        in_byte <= dev_rdata;
        state   <= dev_rdata[`B_REQ_STATE] ? S_P_RD2 : S_P_CLR;
      end
      S_P_CLR: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_INIT_CTL;
        dev_wdata <= 8'h01 << `B_DRIVE;
        status[1] <= 1'b1;
        state     <= S_IDLE;
      end
      S_D_CNT: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_DMA_COUNT;
        dev_wdata <= count;
        state     <= S_D_PLO;
      end
      S_D_PLO: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_DMA_PLOW;
        dev_wdata <= ptr_low;
        state     <= S_D_PHI;
      end
      S_D_PHI: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_DMA_PHIGH;
        dev_wdata <= ptr_high;
        state     <= S_D_MODE;
      end
      S_D_MODE: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_MODE;
        dev_wdata <= 8'h01 << `B_DMA_MODE;
        state     <= S_D_ARM;
      end
      S_D_ARM: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_DMA_STATE;
        dev_wdata <= 8'h01 << `B_XFER_BUSY;
        state     <= S_D_IDLE;
      end
      S_D_IDLE: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_PWR_CTL;
        dev_wdata <= 8'h01 << `B_IDLE_REQ;
        state     <= S_D_POLL;
      end
      S_D_POLL: begin
        if (dev_irq) begin
          state <= S_D_OFF;
        end else begin
          dev_rd    <= 1'b1;
          dev_addr  <= `A_DMA_STATE;
          ret_state <= S_D_CK;
          state     <= S_RWAIT;
        end
      end
      S_D_CK: state <= dev_rdata[`B_XFER_BUSY] ? S_D_POLL : S_D_OFF;
      S_D_OFF: begin
        dev_wr    <= 1'b1;
        dev_addr  <= `A_MODE;
        dev_wdata <= 8'h00;
        state     <= S_D_RDCNT;
      end
      S_D_RDCNT: begin
        dev_rd    <= 1'b1;
        dev_addr  <= `A_DMA_COUNT;
        ret_state <= S_D_CKCNT;
        state     <= S_RWAIT;
      end
      S_D_CKCNT: begin
        left_count <= dev_rdata;
        status[2]  <= 1'b1;
        state      <= S_IDLE;
      end
      S_H_RD: begin
        dev_rd    <= 1'b1;
        dev_addr  <= `A_HIGH_DATA;
        ret_state <= S_H_CK;
        state     <= S_RWAIT;
      end
      S_H_CK: begin
        high_id   <= dev_rdata;
        status[1] <= 1'b1;
        state     <= S_IDLE;
      end
      default: state <= S_IDLE;
    endcase
  end
end

////////////////////////////////////////////////////////////////////////////////
// software read port, data one cycle after the strobe
always @(posedge clk or negedge nrst) begin
  if (!nrst) begin
    rdata <= `RST_BYTE;
  end else if (rd) begin
    case (addr)
      `R_CTRL:    rdata <= {3'h0, state};
      `R_DATA:    rdata <= in_byte;
      `R_COUNT:   rdata <= left_count;
      `R_PLOW:    rdata <= ptr_low;
      `R_PHIGH:   rdata <= ptr_high;
      `R_STATUS:  rdata <= {3'h0, status};
      `R_HIGH_ID: rdata <= high_id;
      default:    rdata <= {5'h00, phase};
    endcase
  end else begin
    rdata <= `RST_BYTE;
  end
end

endmodule

/* File: core/pio_dma_ctl_defs.vh */
`ifndef PIO_DMA_CTL_DEFS_VH
`define PIO_DMA_CTL_DEFS_VH
// device register addresses
`define A_OUT_DATA   16'hFC00
`define A_INIT_CTL   16'hFC01
`define A_MODE       16'hFC02
`define A_TGT_CMD    16'hFC03
`define A_BUS_LINES  16'hFC04
`define A_BUS_PHASE  16'hFC05
`define A_HIGH_DATA  16'hFC08
`define A_DMA_STATE  16'hFC10
`define A_DMA_COUNT  16'hFC11
`define A_DMA_PLOW   16'hFC12
`define A_DMA_PHIGH  16'hFC13
`define A_PWR_CTL    16'h0087
// device field positions
`define B_DRIVE      0
`define B_ACK_ASSERT 4
`define B_REQ_ASSERT 3
`define B_REQ_STATE  5
`define B_PHASE_OK   3
`define B_XFER_BUSY  0
`define B_IDLE_REQ   0
`define B_DMA_MODE   1
// controller register indices
`define R_CTRL       3'h0
`define R_DATA       3'h1
`define R_COUNT      3'h2
`define R_PLOW       3'h3
`define R_PHIGH      3'h4
`define R_STATUS     3'h5
`define R_HIGH_ID    3'h6
`define R_PHASE      3'h7
// reset values
`define RST_BYTE     8'h00
`define RST_ADDR     16'h0000
`endif

/* File: verif/pio_dma_ctl_monitor.sv */
`timescale 1ns/100ps
module pio_dma_ctl_monitor (
  // clock and reset
  input logic        clk,
  input logic        nrst,
  // software port
  input logic        rd,
  input logic [7:0]  rdata,
  // device bus
  input logic [15:0] dev_addr,
  input logic [7:0]  dev_wdata,
  input logic        dev_wr,
  input logic        dev_rd,
  input logic [7:0]  dev_rdata
);
  logic [15:0] lwa;
  logic [15:0] lra;
  logic [7:0]  lwd;
  logic [7:0]  lrv;
  logic        rd_d;
  // last device write, last read address and its answer
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      lwa <= 16'h0000;
      lra <= 16'h0000;
      lwd <= 8'h00;
      lrv <= 8'h00;
      rd_d <= 1'b0;
    end else begin
      rd_d <= dev_rd;
      if (dev_wr) lwa <= dev_addr;
      if (dev_wr) lwd <= dev_wdata;
      if (dev_rd) lra <= dev_addr;
      if (rd_d) lrv <= dev_rdata;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_excl; !(dev_wr && dev_rd); endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
  property p_wgap; dev_wr |-> dev_addr[15:8] == 8'hFC || dev_addr == 16'h0087; endproperty
  a_wgap: assert property (p_wgap) else $error("write outside device registers");
  property p_rgap; dev_rd |=> !dev_rd && !dev_wr; endproperty
  a_rgap: assert property (p_rgap) else $error("read wait");
  property p_rdata; !$past(rd) |-> rdata == 8'h00; endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  property p_req; dev_wr && dev_addr == 16'hFC03 && dev_wdata[3] |-> lwa == 16'hFC00; endproperty
  a_req: assert property (p_req) else $error("request before byte");
  property p_ack; dev_wr && dev_addr == 16'hFC01 && dev_wdata[4]
    |-> lra == 16'hFC05 && lrv[3] && dev_wdata[0]; endproperty
  a_ack: assert property (p_ack) else $error("ack without match");
  property p_rel; dev_wr && dev_addr == 16'hFC01 && lwa == 16'hFC01 && lwd[4]
    |-> lra == 16'hFC04 && !lrv[5] && !dev_wdata[4]; endproperty
  a_rel: assert property (p_rel) else $error("ack release early");
  property p_load; dev_wr && dev_addr == 16'hFC02 && dev_wdata[1] |-> lwa == 16'hFC13; endproperty
  a_load: assert property (p_load) else $error("pointer not loaded");
  property p_arm; dev_wr && dev_addr == 16'hFC10 |-> lwa == 16'hFC02 && lwd[1] && dev_wdata[0];
  endproperty
  a_arm: assert property (p_arm) else $error("arm order");
  property p_idle; dev_wr && dev_addr == 16'h0087 |-> lwa == 16'hFC10 && dev_wdata[0]; endproperty
  a_idle: assert property (p_idle) else $error("idle order");
endmodule
bind pio_dma_ctl pio_dma_ctl_monitor mon (.*);

/* File: verif/dev_model.sv */
`timescale 1ns/100ps
module dev_model (
  // device bus
  input  logic        clk,
  input  logic        nrst,
  input  logic [15:0] dev_addr,
  input  logic [7:0]  dev_wdata,
  input  logic        dev_wr,
  input  logic        dev_rd,
  output logic [7:0]  dev_rdata,
  // scenario knobs
  input  logic [2:0]  high_id_straps,
  input  logic        phase_bad,
  input  logic        dev_irq,
  input  logic [3:0]  dly
);
  logic [7:0] r [0:31];
  logic       req;
  logic       idle;
  logic [3:0] cnt;
  logic [7:0] rv;
  always_comb begin
    rv = r[dev_addr[4:0]];
    if (dev_addr[4:0] == 5'h04) rv = {2'b00, req, 5'h00};
    if (dev_addr[4:0] == 5'h05) rv = {4'h0, !phase_bad, 3'h0};
    if (dev_addr[4:0] == 5'h08) rv = {5'h00, high_id_straps};
  end
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 32; i++) r[i] <= 8'h00;
      dev_rdata <= 8'h00;
      req <= 1'b0;
      idle <= 1'b0;
      cnt <= 4'h0;
    end else begin
      dev_rdata <= dev_rd ? rv : ~dev_rdata;
      // request follows the assert bits after dly clocks
      if (!r[3][3] || req != r[1][4]) cnt <= 4'h0;
      else cnt <= cnt + 4'h1;
      if (!r[3][3]) req <= 1'b0;
      else if (req == r[1][4] && cnt == dly) req <= !req;
      if (dev_wr && dev_addr[15:8] == 8'hFC) r[dev_addr[4:0]] <= dev_wdata;
      if (dev_wr && dev_addr == 16'h0087) idle <= dev_wdata[0];
      // one byte per clock once idle, core always requesting
      if (r[16][0] && idle && r[2][1]) begin
        if (dev_irq || r[17] == 8'h00) begin
          r[16][0] <= 1'b0;
          idle <= 1'b0;
        end else begin
          r[17] <= r[17] - 8'h01;
          {r[19], r[18]} <= {r[19], r[18]} + 16'h0001;
        end
      end
    end
  end
endmodule

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module testbench;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [2:0]  addr = 3'h0;
  logic [7:0]  wdata = 8'h00;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [7:0]  rdata;
  logic [7:0]  dev_rdata;
  logic [7:0]  dev_wdata;
  logic [7:0]  v;
  logic [15:0] dev_addr;
  logic        dev_wr;
  logic        dev_rd;
  logic        dev_irq = 1'b0;
  logic        phase_bad = 1'b0;
  logic [2:0]  high_id_straps = 3'h5;
  logic [3:0]  dly = 4'hC;
  int          failures = 0;
  int          samples_checked = 0;
  always #20 clk = ~clk;
  pio_dma_ctl uut (
    .clk       (clk),
    .nrst      (nrst),
    .addr      (addr),
    .wdata     (wdata),
    .wr        (wr),
    .rd        (rd),
    .rdata     (rdata),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .dev_rdata (dev_rdata),
    .dev_irq   (dev_irq)
  );
  dev_model dev (
    .clk            (clk),
    .nrst           (nrst),
    .dev_addr       (dev_addr),
    .dev_wdata      (dev_wdata),
    .dev_wr         (dev_wr),
    .dev_rd         (dev_rd),
    .dev_rdata      (dev_rdata),
    .high_id_straps (high_id_straps),
    .phase_bad      (phase_bad),
    .dev_irq        (dev_irq),
    .dly            (dly)
  );
  // tasks start in the time step of a rising edge; one idle cycle ends each access
  task automatic sw_write(input logic [2:0] a, input logic [7:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    @(posedge clk);
  endtask
  task automatic sw_read(input logic [2:0] a);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    @(negedge clk);
    v = rdata;
    @(posedge clk);
  endtask
  // start a command, try a phase write while busy, poll status until idle
  task automatic run(input logic [7:0] go);
    int n;
    n = 0;
    sw_write(3'h5, 8'h1E);
    sw_write(3'h0, go);
    sw_write(3'h7, 8'h05);
    v = 8'h01;
    while (v[0] !== 1'b0 && n < 400) begin
      sw_read(3'h5);
      n++;
    end
    `CHK("poll_limit", 1'b1, n < 400)
  endtask
  task automatic tally_and_finish;
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    run(8'h04);
    `CHK("hid_done", 8'h02, v)
    sw_read(3'h6);
    `CHK("hid", 8'h05, v)
    sw_write(3'h1, 8'hA5);
    sw_write(3'h7, 8'h02);
    run(8'h01);
    `CHK("pio_done", 8'h02, v)
    `CHK("pio_byte", 8'hA5, dev.r[0])
    `CHK("pio_ack", 8'h01, dev.r[1])
    `CHK("pio_phase", 3'h2, dev.r[3][2:0])
    sw_read(3'h7);
    `CHK("refused", 8'h02, v)
    sw_read(3'h1);
    `CHK("pio_lines", 8'h00, v)
    dly <= 4'h0;
    phase_bad <= 1'b1;
    run(8'h01);
    `CHK("mismatch", 1'b1, v[3])
    `CHK("no_ack", 1'b0, dev.r[1][4])
    phase_bad <= 1'b0;
    sw_write(3'h2, 8'h04);
    sw_write(3'h3, 8'hFF);
    sw_write(3'h4, 8'h12);
    run(8'h02);
    `CHK("dma_done", 8'h04, v)
    `CHK("dma_ptr", 16'h1303, {dev.r[19], dev.r[18]})
    sw_read(3'h2);
    `CHK("dma_left", 8'h00, v)
    sw_read(3'h3);
    `CHK("ptr_low", 8'hFF, v)
    dev_irq <= 1'b1;
    sw_write(3'h2, 8'h08);
    sw_write(3'h3, 8'h10);
    sw_write(3'h4, 8'h00);
    run(8'h02);
    `CHK("irq_seen", 1'b1, v[4])
    `CHK("halt_ptr", 16'h0010, {dev.r[19], dev.r[18]})
    `CHK("mode_off", 1'b0, dev.r[2][1])
    sw_read(3'h2);
    `CHK("halt_left", 8'h08, v)
    dev_irq <= 1'b0;
    run(8'h08);
    `CHK("no_go", 8'h00, v)
    sw_read(3'h0);
    `CHK("state_idle", 8'h00, v)
    tally_and_finish();
  end
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
endmodule
